/* File: bench/sac_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model (
    // clock and requests
    input wire logic ref_clk_i,
    input wire logic cal_run_i,
    input wire logic sup_run_i,
    // behaviour chosen by the bench
    input wire logic ok_i,
    input wire logic hang_i,
    input wire logic [7:0] val_i,
    input wire logic [5:0] fault_i,
    // answers
    output logic cal_done_o,
    output logic cal_ok_o,
    output logic [7:0] cal_value_o,
    output logic sup_done_o,
    output logic [5:0] sup_fault_o
);
    int cnt = 0;
    int scnt = 0;
    always @(posedge ref_clk_i) begin
        cnt <= cal_run_i ? cnt + 1 : 0;
        scnt <= sup_run_i ? scnt + 1 : 0;
    end
    // released lines show the inverse so a stale value cannot pass
    assign cal_done_o = cal_run_i && !hang_i && cnt >= 8;
    assign cal_ok_o = (cnt >= 6) ? ok_i : !ok_i;
    assign cal_value_o = (cnt >= 6) ? val_i : ~val_i;
    assign sup_done_o = sup_run_i && scnt >= 6;
    assign sup_fault_o = (scnt >= 2) ? fault_i : ~fault_i;
endmodule // sac_analog_model
`default_nettype wire

/* File: bench/sac_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_top_props #(
    parameter int CAL_MAX_CYC = 20
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // inputs
    input wire logic config_mode_i,
    input wire logic selftest_mode_i,
    input wire logic [5:0] ref_trim_i,
    input wire logic ref_trim_we_i,
    input wire logic gain_reg_toggle_i,
    input wire logic cal_start_i,
    input wire logic cal_abort_i,
    input wire logic [2:0] oc_above_i,
    // outputs
    input wire logic [1:0] ref_level_o,
    input wire logic [5:0] ref_trim_o,
    input wire logic gain_reg_sel_o,
    input wire logic [1:0] oc_filter_sel_o,
    input wire logic [2:0] test_volt_low_o,
    input wire logic [2:0] test_volt_high_o,
    input wire logic [2:0] cal_active_o,
    input wire logic cal_busy_o,
    input wire logic sup_run_o,
    input wire logic temp_hold_o,
    input wire logic [2:0] oc_flag_o
);
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    // ------
    // helper counters
    // ------
    logic [2:0] seen_r;
    logic [15:0] act_r;
    logic [15:0] hi_r;
    int lim;
    // only amp 1 is counted; the filter limit is shared by all three
    assign lim = (oc_filter_sel_o == 2'h0) ? 300 :
        (oc_filter_sel_o == 2'h1) ? 600 :
        (oc_filter_sel_o == 2'h2) ? 1000 : 2000;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            seen_r <= 3'h0;
            act_r <= 16'h0;
            hi_r <= 16'h0;
        end else begin
            seen_r <= cal_busy_o ? (seen_r | cal_active_o) : 3'h0;
            act_r <= (cal_active_o != 3'h0) ? act_r + 16'h1 : 16'h0;
            hi_r <= oc_above_i[0] ? hi_r + 16'h1 : 16'h0;
        end
    end
    // ------
    // properties
    // ------
    level_legal_a: assert property (
        ref_level_o == 2'h1 || ref_level_o == 2'h2)
        else $error("reference level holds a reserved code");
    trim_write_a: assert property (
        ref_trim_we_i |=> ref_trim_o == $past(ref_trim_i))
        else $error("trim write not applied");
    gain_toggle_a: assert property (
        gain_reg_toggle_i |=> gain_reg_sel_o != $past(gain_reg_sel_o))
        else $error("gain register select did not flip");
    cal_onehot_a: assert property ($onehot0(cal_active_o))
        else $error("more than one amplifier calibrating");
    cal_order_a: assert property (
        cal_active_o != 3'h0 |-> (seen_r & ~cal_active_o) < cal_active_o)
        else $error("calibration order broken");
    cal_time_a: assert property (act_r <= CAL_MAX_CYC + 2)
        else $error("calibration of one amplifier too long");
    cal_config_a: assert property (
        config_mode_i && cal_start_i && !cal_busy_o |=> !cal_busy_o)
        else $error("calibration started in configuration mode");
    cal_abort_a: assert property (
        cal_abort_i |-> ##[1:2] cal_active_o == 3'h0)
        else $error("abort did not stop calibration");
    oc_filter_a: assert property (
        $rose(oc_flag_o[0]) |-> hi_r >= lim)
        else $error("overcurrent flagged before filter time");
    oc_restart_a: assert property (
        !oc_above_i[0] [*5] |-> !oc_flag_o[0])
        else $error("overcurrent flag kept while below");
    test_mode_a: assert property (
        !selftest_mode_i [*3] |-> (test_volt_low_o | test_volt_high_o) == 3'h0)
        else $error("gain test active outside self-test");
    sup_hold_a: assert property (sup_run_o |-> temp_hold_o)
        else $error("temperature readout not held during check");
    cover property (cal_active_o == 3'h4);
    cover property ($rose(oc_flag_o[0]));
    cover property ($rose(sup_run_o));
endmodule // sac_top_props
bind sac_top sac_top_props #(.CAL_MAX_CYC(CAL_MAX_CYC)) sac_top_props_i (.*);
`default_nettype wire

/* File: bench/test_shunt_amp_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_shunt_amp_control;
    localparam int CAL_CYC = 20;
    logic clk = 1'b0;
    logic rst, cfg, st, lvl_we, trim_we, gain_we, tog, cal_st, abrt;
    logic thr, ocw, schk, eclr, m_ok, m_hang, c_done, c_ok, s_done;
    logic [1:0] lvl, ocf, lvl_o, ocf_o;
    logic [2:0] sel, lo_en, hi_en, above, tvl, tvh, blk, act, flag;
    logic [5:0] trim, fault, trim_o, s_fault;
    logic [7:0] c_val, e12, e3;
    logic [8:0] ord, gain_o;
    logic [17:0] gf;
    logic [23:0] cval;
    logic gsel, thr_o, run, busy, srun, thold;
    int errors = 0;
    int samples_checked = 0;
    integer seed = 32'hcd4278e7;
    int k, a, lim;
    always #2.5 clk = ~clk;
    sac_analog_model sac_analog_model_i (.ref_clk_i(clk), .cal_run_i(run),
        .sup_run_i(srun), .ok_i(m_ok), .hang_i(m_hang),
        .val_i({5'h0a, act}), .fault_i(fault), .cal_done_o(c_done),
        .cal_ok_o(c_ok), .cal_value_o(c_val), .sup_done_o(s_done),
        .sup_fault_o(s_fault));
    sac_top #(.CAL_MAX_CYC(CAL_CYC)) sac_top_i (.ref_clk_i(clk),
        .reset_i(rst), .config_mode_i(cfg), .selftest_mode_i(st),
        .ref_level_i(lvl), .ref_level_we_i(lvl_we), .ref_trim_i(trim),
        .ref_trim_we_i(trim_we), .amp_gain_field_i(gf), .gain_we_i(gain_we),
        .gain_reg_toggle_i(tog), .cal_start_i(cal_st), .cal_select_i(sel),
        .cal_abort_i(abrt), .cal_done_i(c_done), .cal_ok_i(c_ok),
        .cal_value_i(c_val), .oc_thresh_sel_i(thr), .oc_filter_sel_i(ocf),
        .oc_cfg_we_i(ocw), .oc_above_i(above), .low_gain_test_en_i(lo_en),
        .high_gain_test_en_i(hi_en), .sup_check_i(schk),
        .sup_done_i(s_done), .sup_fault_i(s_fault), .err_clear_i(eclr),
        .ref_level_o(lvl_o), .ref_trim_o(trim_o), .amp_gain_o(gain_o),
        .gain_reg_sel_o(gsel), .oc_thresh_sel_o(thr_o),
        .oc_filter_sel_o(ocf_o), .test_volt_low_o(tvl),
        .test_volt_high_o(tvh), .input_block_o(blk), .cal_active_o(act),
        .cal_run_o(run), .cal_value_o(cval), .cal_busy_o(busy),
        .sup_run_o(srun), .temp_hold_o(thold), .oc_flag_o(flag),
        .amp12_error_flags_o(e12), .amp3_error_flags_o(e3));
    // ------
    // shared tasks
    // ------
    task automatic complete_run();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic hang_out();
        errors++;
        complete_run();
    endtask
    // records the order in which amplifiers become active
    task automatic run_cal(input logic [2:0] s, input logic do_abort);
        logic [2:0] last;
        int i;
        ord = 9'h0;
        last = 3'h0;
        sel = s;
        pulse(cal_st);
        for (i = 0; i < 400 && (busy !== 1'b0 || i < 3); i++) begin
            if (act !== last && act !== 3'h0) begin
                ord = {ord[5:0], act};
            end
            last = act;
            check(run, act !== 3'h0, "run follows active");
            abrt = do_abort && act !== 3'h0;
            step(1);
        end
        abrt = 1'b0;
        if (i == 400) begin
            hang_out();
        end
    endtask
    task automatic sup_wait(input logic [5:0] f);
        int i;
        step(3);
        check(srun, 1'b1, "supply check not running");
        check(thold, 1'b1, "temperature not held");
        for (i = 0; i < 60 && srun !== 1'b0; i++) begin
            step(1);
        end
        if (i == 60) begin
            hang_out();
        end
        check(e12, {1'b0, f[3:2], 2'h0, f[1:0], 1'b0}, "e12 flags");
        check(e3, {5'h0, f[5:4], 1'b0}, "e3 flags");
        pulse(eclr);
    endtask
    function automatic int lim_of(input int c);
        return (c == 0) ? 300 : (c == 1) ? 600 : (c == 2) ? 1000 : 2000;
    endfunction
    // ------
    // main sequence
    // ------
    initial begin
        {rst, cfg, st, lvl_we, trim_we, gain_we, tog, cal_st} = 8'hc0;
        {abrt, thr, ocw, schk, eclr, m_ok, m_hang} = 7'h02;
        {lvl, ocf, sel, lo_en, hi_en, above} = 16'h0;
        {trim, fault, gf} = 30'h0;
        step(2);
        rst = 1'b0;
        step(1);
        check(lvl_o, 2'h1, "level reset");
        check(trim_o, 6'h1f, "trim reset");
        check({thr_o, ocf_o}, 3'h2, "oc reset");
        for (k = 0; k < 4; k++) begin
            lvl = k[1:0];
            pulse(lvl_we);
            step(1);
            check(lvl_o, (k >= 2) ? 2'h2 : 2'h1, "level write");
        end
        for (k = 0; k < 6; k++) begin
            trim = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($random(seed));
            pulse(trim_we);
            step(1);
            check(trim_o, trim, "trim write");
        end
        gf = 18'($random(seed));
        pulse(gain_we);
        step(2);
        check(gain_o, {gf[14:12], gf[8:6], gf[2:0]}, "gain 1");
        pulse(tog);
        step(2);
        check(gsel, 1'b1, "select read");
        check(gain_o, {gf[17:15], gf[11:9], gf[5:3]}, "gain 2");
        lo_en = 3'h7;
        hi_en = 3'h3;
        step(3);
        check({tvl, tvh}, 6'h0, "test outside self-test");
        st = 1'b1;
        step(3);
        check({tvl, tvh}, 6'h03, "high test");
        check(blk, 3'h3, "input block high");
        pulse(tog);
        step(3);
        check({tvl, tvh}, 6'h38, "low test");
        check(blk, 3'h7, "input block low");
        {lo_en, hi_en} = 6'h0;
        sel = 3'h1;
        pulse(cal_st);
        step(2);
        check(busy, 1'b0, "start in config");
        fault = 6'($random(seed));
        pulse(schk);
        sup_wait(fault);
        st = 1'b0;
        pulse(schk);
        step(3);
        check(srun, 1'b0, "check outside self-test");
        fault = 6'h2a;
        cfg = 1'b0;
        sup_wait(fault);
        check(gsel, 1'b0, "gain register 1 for calibration");
        run_cal(3'h7, 1'b0);
        check(ord, 9'h054, "order");
        check(cval, 24'h545251, "values");
        check(e12, 8'h0, "no error");
        run_cal(3'h5, 1'b0);
        check(ord, 9'h00c, "skip unselected");
        m_ok = 1'b0;
        run_cal(3'h2, 1'b0);
        check(e12[4], 1'b1, "fail flag");
        check(cval, 24'h545251, "kept after fail");
        {m_ok, m_hang} = 2'h3;
        run_cal(3'h4, 1'b0);
        check(e3[0], 1'b1, "timeout flag");
        check(cval, 24'h545251, "kept after timeout");
        run_cal(3'h3, 1'b1);
        check(ord, 9'h001, "abort");
        for (k = 0; k < 4; k++) begin
            ocf = k[1:0];
            thr = k[0];
            pulse(ocw);
            step(1);
            check({thr_o, ocf_o}, {thr, ocf}, "oc config");
            lim = lim_of(k);
            a = (k == 0) ? 0 : {$random(seed)} % 3;
            above = 3'h1 << a;
            step(lim - 8);
            above = 3'h0;
            step(2);
            above = 3'h1 << a;
            step(lim - 4);
            check(flag, 3'h0, "flag early");
            step(10);
            check(flag, 3'h1 << a, "flag");
            above = 3'h0;
            step(6);
            check(flag, 3'h0, "flag drop");
        end
        complete_run();
    end
endmodule // test_shunt_amp_control
`default_nettype wire

/* File: hdl/sac_oc_filter.v */
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.vh"

module sac_oc_filter #(
    parameter CW = 11
) (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // comparator level and limit
    input wire above_i,
    input wire [CW-1:0] limit_i,
    // result
    output reg flag_o
);

    reg [CW-1:0] cnt_r;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= {CW{1'b0}};
            flag_o <= 1'b0;
        end else if (!above_i) begin
            cnt_r <= {CW{1'b0}};
            flag_o <= 1'b0;
        end else if (cnt_r >= limit_i) begin
            flag_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
    end

endmodule // sac_oc_filter
`default_nettype wire

/* File: hdl/sac_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.vh"

module sac_top #(
    parameter CAL_MAX_CYC = `SAC_CAL_MAX_CYC
) (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // mode from the device mode logic
    input wire config_mode_i,
    input wire selftest_mode_i,
    // reference buffer settings
    input wire [1:0] ref_level_i,
    input wire ref_level_we_i,
    input wire [5:0] ref_trim_i,
    input wire ref_trim_we_i,
    // gain fields, three amplifiers, two registers each
    input wire [17:0] amp_gain_field_i,
    input wire gain_we_i,
    input wire gain_reg_toggle_i,
    // calibration control
    input wire cal_start_i,
    input wire [2:0] cal_select_i,
    input wire cal_abort_i,
    // analog calibration engine handshake (pins, synchronised)
    input wire cal_done_i,
    input wire cal_ok_i,
    input wire [7:0] cal_value_i,
    // overcurrent
    input wire oc_thresh_sel_i,
    input wire [1:0] oc_filter_sel_i,
    input wire oc_cfg_we_i,
    input wire [2:0] oc_above_i,
    // gain test and supply monitor
    input wire [2:0] low_gain_test_en_i,
    input wire [2:0] high_gain_test_en_i,
    input wire sup_check_i,
    input wire sup_done_i,
    input wire [5:0] sup_fault_i,
    input wire err_clear_i,
    // settings to the analog front end
    output reg [1:0] ref_level_o,
    output reg [5:0] ref_trim_o,
    output reg [8:0] amp_gain_o,
    output reg gain_reg_sel_o,
    output reg oc_thresh_sel_o,
    output reg [1:0] oc_filter_sel_o,
    output reg [2:0] test_volt_low_o,
    output reg [2:0] test_volt_high_o,
    output reg [2:0] input_block_o,
    // calibration
    output reg [2:0] cal_active_o,
    output reg cal_run_o,
    output reg [23:0] cal_value_o,
    output reg cal_busy_o,
    // supply monitor and temperature
    output reg sup_run_o,
    output reg temp_hold_o,
    // status
    output reg [2:0] oc_flag_o,
    output reg [7:0] amp12_error_flags_o,
    output reg [7:0] amp3_error_flags_o
);

    // ----------------------------------------
    // local constants
    // ----------------------------------------
    localparam CW = 11;
    localparam TW = 16;
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_NEXT = 2'h2;
    localparam integer CAL_LAST = CAL_MAX_CYC - 1;
    localparam integer LIM0 = `SAC_NS2CYC(`SAC_OCF_T0_NS);
    localparam integer LIM1 = `SAC_NS2CYC(`SAC_OCF_T1_NS);
    localparam integer LIM2 = `SAC_NS2CYC(`SAC_OCF_T2_NS);
    localparam integer LIM3 = `SAC_NS2CYC(`SAC_OCF_T3_NS);

    function [1:0] first_amp;
        input [2:0] pend;
        begin
            if (pend[0]) begin
                first_amp = 2'h0;
            end else if (pend[1]) begin
                first_amp = 2'h1;
            end else begin
                first_amp = 2'h2;
            end
        end
    endfunction

    function [CW-1:0] filt_cyc;
        input [1:0] code;
        begin
            case (code)
                2'h0: filt_cyc = LIM0[CW-1:0];
                2'h1: filt_cyc = LIM1[CW-1:0];
                2'h2: filt_cyc = LIM2[CW-1:0];
                default: filt_cyc = LIM3[CW-1:0];
            endcase
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [2:0] s1_r;
    reg [2:0] s2_r;
    reg [2:0] oc_s1_r;
    reg [2:0] oc_s2_r;
    reg [5:0] sf_s1_r;
    reg [5:0] sf_s2_r;
    reg [7:0] cv_s1_r;
    reg [7:0] cv_s2_r;
    wire done_s = s2_r[0];
    wire ok_s = s2_r[1];
    wire sdone_s = s2_r[2];

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            oc_s1_r <= 3'h0;
            oc_s2_r <= 3'h0;
            sf_s1_r <= 6'h00;
            sf_s2_r <= 6'h00;
            cv_s1_r <= 8'h00;
            cv_s2_r <= 8'h00;
        end else begin
            s1_r <= {sup_done_i, cal_ok_i, cal_done_i};
            s2_r <= s1_r;
            oc_s1_r <= oc_above_i;
            oc_s2_r <= oc_s1_r;
            sf_s1_r <= sup_fault_i;
            sf_s2_r <= sf_s1_r;
            cv_s1_r <= cal_value_i;
            cv_s2_r <= cv_s1_r;
        end
    end

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    reg [17:0] gain_r;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_level_o <= `SAC_ZCL_RST;
            ref_trim_o <= `SAC_OFS_RST;
            gain_r <= {6{`SAC_GAIN_RST}};
            gain_reg_sel_o <= 1'b0;
            oc_thresh_sel_o <= `SAC_OCT_RST;
            oc_filter_sel_o <= `SAC_OCF_RST;
        end else begin
            // reserved level codes are refused, old level stays
            if (ref_level_we_i && (ref_level_i == `SAC_ZCL_RST ||
                ref_level_i == `SAC_ZCL_2V5)) begin
                ref_level_o <= ref_level_i;
            end
            if (ref_trim_we_i) begin
                ref_trim_o <= ref_trim_i;
            end
            if (gain_we_i) begin
                gain_r <= amp_gain_field_i;
            end
            if (gain_reg_toggle_i) begin
                gain_reg_sel_o <= ~gain_reg_sel_o;
            end
            if (oc_cfg_we_i) begin
                oc_thresh_sel_o <= oc_thresh_sel_i;
                oc_filter_sel_o <= oc_filter_sel_i;
            end
        end
    end

    // ----------------------------------------
    // gain routing and gain test
    // ----------------------------------------
    integer i;
    reg [8:0] gsel;
    reg [2:0] tl_nxt;
    reg [2:0] th_nxt;

    always @* begin
        gsel = 9'h000;
        for (i = 0; i < 3; i = i + 1) begin
            // field layout: amp i register 1 at 6i, register 2 at 6i+3
            gsel[3*i +: 3] = gain_reg_sel_o ? gain_r[6*i+3 +: 3] :
                gain_r[6*i +: 3];
        end
        tl_nxt = selftest_mode_i && !gain_reg_sel_o ?
            low_gain_test_en_i : 3'h0;
        th_nxt = selftest_mode_i && gain_reg_sel_o ?
            high_gain_test_en_i : 3'h0;
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            amp_gain_o <= 9'h000;
            test_volt_low_o <= 3'h0;
            test_volt_high_o <= 3'h0;
            input_block_o <= 3'h0;
        end else begin
            amp_gain_o <= gsel;
            test_volt_low_o <= tl_nxt;
            test_volt_high_o <= th_nxt;
            input_block_o <= tl_nxt | th_nxt;
        end
    end

    // ----------------------------------------
    // overcurrent filters, shared limit
    // ----------------------------------------
    reg [CW-1:0] limit_r;
    wire [2:0] oc_hit;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            limit_r <= LIM2[CW-1:0];
            oc_flag_o <= 3'h0;
        end else begin
            limit_r <= filt_cyc(oc_filter_sel_o);
            oc_flag_o <= oc_hit;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_oc
            sac_oc_filter #(
                .CW(CW)
            ) u_filt (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .above_i(oc_s2_r[g]),
                .limit_i(limit_r),
                .flag_o(oc_hit[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // calibration sequencer
    // ----------------------------------------
    reg [1:0] st_r;
    reg [2:0] pend_r;
    reg [1:0] cur_r;
    reg [TW-1:0] tmr_r;
    reg [2:0] cal_fail;
    reg [2:0] done_p;
    reg done_d_r;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= ST_IDLE;
            pend_r <= 3'h0;
            cur_r <= 2'h0;
            tmr_r <= {TW{1'b0}};
            cal_active_o <= 3'h0;
            cal_run_o <= 1'b0;
            cal_busy_o <= 1'b0;
            cal_value_o <= 24'h000000;
            cal_fail <= 3'h0;
            done_d_r <= 1'b0;
        end else begin
            cal_fail <= 3'h0;
            done_d_r <= done_s;
            case (st_r)
                ST_IDLE: begin
                    // config mode drops requests silently
                    if (cal_start_i && !config_mode_i &&
                        cal_select_i != 3'h0) begin
                        pend_r <= cal_select_i;
                        st_r <= ST_NEXT;
                        cal_busy_o <= 1'b1;
                    end
                end
                ST_NEXT: begin
                    if (pend_r == 3'h0 || cal_abort_i || config_mode_i) begin
                        // an abort between two amplifiers drops the rest
                        pend_r <= 3'h0;
                        st_r <= ST_IDLE;
                        cal_busy_o <= 1'b0;
                    end else begin
                        cur_r <= first_amp(pend_r);
                        cal_active_o <= 3'h1 << first_amp(pend_r);
                        cal_run_o <= 1'b1;
                        tmr_r <= {TW{1'b0}};
                        st_r <= ST_RUN;
                    end
                end
                default: begin
                    tmr_r <= tmr_r + {{(TW-1){1'b0}}, 1'b1};
                    if (cal_abort_i || config_mode_i) begin
                        // abort ends the whole sequence, value untouched
                        pend_r <= 3'h0;
                        cal_active_o <= 3'h0;
                        cal_run_o <= 1'b0;
                        st_r <= ST_NEXT;
                    // rising edge only: a stale done of the previous amp
                    end else if ((done_s && !done_d_r) ||
                        tmr_r >= CAL_LAST[TW-1:0]) begin
                        if (done_s && ok_s) begin
                            cal_value_o[8*cur_r +: 8] <= cv_s2_r;
                        end else begin
                            cal_fail <= 3'h1 << cur_r;
                        end
                        pend_r <= pend_r & ~(3'h1 << cur_r);
                        cal_active_o <= 3'h0;
                        cal_run_o <= 1'b0;
                        st_r <= ST_NEXT;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // supply monitor
    // ----------------------------------------
    reg cfg_d_r;
    reg sd_d_r;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_d_r <= 1'b1;
            sd_d_r <= 1'b0;
            sup_run_o <= 1'b0;
            temp_hold_o <= 1'b0;
        end else begin
            cfg_d_r <= config_mode_i;
            sd_d_r <= sdone_s;
            if ((sup_check_i && selftest_mode_i) ||
                (cfg_d_r && !config_mode_i)) begin
                sup_run_o <= 1'b1;
                temp_hold_o <= 1'b1;
            end else if (sup_run_o && sdone_s && !sd_d_r) begin
                sup_run_o <= 1'b0;
                temp_hold_o <= 1'b0;
            end
        end
    end

    always @* begin
        done_p = {3{sup_run_o && sdone_s && !sd_d_r}};
    end

    // ----------------------------------------
    // error flags, set wins over clear
    // ----------------------------------------
    reg [7:0] e12_set;
    reg [7:0] e3_set;

    always @* begin
        e12_set = 8'h00;
        e3_set = 8'h00;
        e12_set[`SAC_E12_CAL1] = cal_fail[0];
        e12_set[`SAC_E12_CAL2] = cal_fail[1];
        e3_set[`SAC_E3_CAL3] = cal_fail[2];
        // faults only flag, nothing else reacts to them
        e12_set[`SAC_E12_SUP1A] = done_p[0] & sf_s2_r[0];
        e12_set[`SAC_E12_SUP1B] = done_p[0] & sf_s2_r[1];
        e12_set[`SAC_E12_SUP2A] = done_p[1] & sf_s2_r[2];
        e12_set[`SAC_E12_SUP2B] = done_p[1] & sf_s2_r[3];
        e3_set[`SAC_E3_SUPA] = done_p[2] & sf_s2_r[4];
        e3_set[`SAC_E3_SUPB] = done_p[2] & sf_s2_r[5];
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            amp12_error_flags_o <= 8'h00;
            amp3_error_flags_o <= 8'h00;
        end else if (err_clear_i) begin
            amp12_error_flags_o <= e12_set;
            amp3_error_flags_o <= e3_set;
        end else begin
            amp12_error_flags_o <= amp12_error_flags_o | e12_set;
            amp3_error_flags_o <= amp3_error_flags_o | e3_set;
        end
    end

endmodule // sac_top
`default_nettype wire

/* File: shared/sac_defs.vh */
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// ----------------------------------------
// reference level and trim
// ----------------------------------------
`define SAC_ZCL_RST 2'h1
`define SAC_ZCL_2V5 2'h2
`define SAC_OFS_RST 6'h1f

// ----------------------------------------
// overcurrent filter, times in ns
// ----------------------------------------
`define SAC_CLK_MHZ 200
`define SAC_OCF_RST 2'h2
`define SAC_OCT_RST 1'b0
`define SAC_OCF_T0_NS 1500
`define SAC_OCF_T1_NS 3000
`define SAC_OCF_T2_NS 5000
`define SAC_OCF_T3_NS 10000
`define SAC_NS2CYC(ns) (((ns) * `SAC_CLK_MHZ) / 1000)

// ----------------------------------------
// calibration and gain defaults
// ----------------------------------------
`define SAC_CAL_MAX_CYC 4000
`define SAC_GAIN_RST 3'h0

// ----------------------------------------
// error flag bit positions
// ----------------------------------------
`define SAC_E12_CAL1 0
`define SAC_E12_SUP1A 1
`define SAC_E12_SUP1B 2
`define SAC_E12_CAL2 4
`define SAC_E12_SUP2A 5
`define SAC_E12_SUP2B 6
`define SAC_E3_CAL3 0
`define SAC_E3_SUPA 1
`define SAC_E3_SUPB 2

`endif
